// ---- src/acwsl_pkg.sv ----
// Operation
// - Word shifted in MSB first, 14 rising edges
// - Capture runs on serial clock edges only
// - Write anytime; applied when conversion ends
// - Readback sends config word after result LSB
// - Top bit 0 keeps, 1 overwrites settings
// - Mode 00x/010/011: bipolar pairs, bipolar COM, temperature
// - Mode 10x/110/111: unipolar pairs, GND sense, single-ended
// - Word written in conversion N applies N+1
// - Reference codes 010, 011, 110 decoded
package acwsl_pkg;
    localparam int CFG_W = 14;
    localparam int RES_W = 16;
    localparam int RB_W  = RES_W + CFG_W;
    localparam int CNT_W = 5;

    localparam int UPD_BIT  = 13;
    localparam int MODE_HI  = 12;
    localparam int MODE_LO  = 10;
    localparam int CHAN_HI  = 9;
    localparam int CHAN_LO  = 7;
    localparam int REF_HI   = 5;
    localparam int REF_LO   = 3;

    localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;
    localparam logic [RES_W-1:0] RES_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_CFG   = 5'h0e;
    localparam logic [CNT_W-1:0] CNT_RES   = 5'h10;
    localparam logic [CNT_W-1:0] CNT_RB    = 5'h1e;
    localparam logic [CNT_W-1:0] RB_TOP    = 5'h1d;

    localparam logic [1:0] MODE_BIP_PAIRS = 2'h0;
    localparam logic [1:0] MODE_UNI_PAIRS = 2'h2;
    localparam logic [2:0] MODE_BIP_COM   = 3'h2;
    localparam logic [2:0] MODE_TEMP      = 3'h3;
    localparam logic [2:0] MODE_UNI_GS    = 3'h6;
    localparam logic [2:0] MODE_UNI_SE    = 3'h7;

    localparam logic [2:0] REF_EXT_NOBUF = 3'h2;
    localparam logic [2:0] REF_EXT_BUF   = 3'h3;
    localparam logic [2:0] REF_ALL_OFF   = 3'h6;

    typedef enum logic [2:0] {
        ACWSL_BIP_PAIRS,
        ACWSL_BIP_COM,
        ACWSL_TEMP_SENSOR,
        ACWSL_UNI_PAIRS,
        ACWSL_UNI_GND_SENSE,
        ACWSL_UNI_SINGLE
    } acwsl_mode_e;
endpackage

// ---- src/acwsl_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module acwsl_core
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       sck,
    input  wire logic                       cnv,
    input  wire logic                       din,
    input  wire logic                       readback_en,
    input  wire logic                       conv_done,
    input  wire logic [acwsl_pkg::RES_W-1:0] result_data,
    output var  logic                       sdo,
    output var  logic [acwsl_pkg::CFG_W-1:0] configuration_word,
    output var  acwsl_pkg::acwsl_mode_e     input_mode_field,
    output var  logic [2:0]                 channel_select_field,
    output var  logic                       ref_ext,
    output var  logic                       ref_int_en,
    output var  logic                       ref_buf_en,
    output var  logic                       temp_en
);
    import acwsl_pkg::*;

    // Serial clock domain
    logic                 frame_rst_n;
    logic [CNT_W-1:0]     bit_cnt;
    logic [CNT_W-1:0]     rb_cnt;
    logic [CFG_W-1:0]     shift_word;
    logic                 word_tgl;

    // Reference clock domain
    logic                 tgl_s1;
    logic                 tgl_s2;
    logic                 tgl_s3;
    logic                 word_evt;
    logic [CFG_W-1:0]     pend_word;
    logic                 pend_valid;
    logic [RES_W-1:0]     rb_res;
    logic [CFG_W-1:0]     rb_cfg;
    logic [RB_W-1:0]      rb_vec;
    logic [CFG_W-1:0]     next_cfg;

    // A high convert pin ends the frame, so a stopped serial clock needs no
    // trailing edge to rearm the counters.
    assign frame_rst_n = rst_n & ~cnv;

    // Only the first 14 rising edges of a frame load the word; later edges
    // (result readout) leave it alone.
    always_ff @(posedge sck or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_cnt <= '0;
        end
        else if (bit_cnt < CNT_CFG)
        begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_word <= CFG_RESET;
            word_tgl   <= 1'b0;
        end
        else if (bit_cnt < CNT_CFG)
        begin
            shift_word <= {shift_word[CFG_W-2:0], din};
            if (bit_cnt == CNT_CFG - 5'h01)
            begin
                word_tgl <= ~word_tgl;
            end
        end
    end

    // Result bits, then the configuration word if readback is on. The
    // readback words change only at conversion end, while no data access
    // is allowed, so they are quasi-static when sampled here.
    assign rb_vec = {rb_res, rb_cfg};

    always_ff @(negedge sck or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            rb_cnt <= '0;
        end
        else if (rb_cnt < CNT_RB)
        begin
            rb_cnt <= rb_cnt + 5'h01;
        end
    end

    always_ff @(negedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdo <= 1'b0;
        end
        else if (rb_cnt < CNT_RES || (readback_en && rb_cnt < CNT_RB))
        begin
            sdo <= rb_vec[RB_TOP - rb_cnt];
        end
        else
        begin
            sdo <= 1'b0;
        end
    end

    // Toggle crossing; the word stays put until the next frame, which is
    // far longer than the three reference clocks the sync takes.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end
        else
        begin
            tgl_s1 <= word_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    assign word_evt = tgl_s2 ^ tgl_s3;

    // A word with the update bit clear leaves the pending state untouched,
    // so a host that keeps data-in low while reading causes no rewrite.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_word  <= CFG_RESET;
            pend_valid <= 1'b0;
        end
        else if (word_evt && shift_word[UPD_BIT])
        begin
            pend_word  <= shift_word;
            pend_valid <= 1'b1;
        end
        else if (conv_done)
        begin
            pend_valid <= 1'b0;
        end
    end

    // Power-up contents are meaningless to the host until two dummy
    // conversions; reset still gives them a known value.
    assign next_cfg = (conv_done && pend_valid) ? pend_word : configuration_word;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            configuration_word <= CFG_RESET;
        end
        else
        begin
            configuration_word <= next_cfg;
        end
    end

    // Result N is tagged with the word that was active during conversion N.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rb_res <= RES_RESET;
            rb_cfg <= CFG_RESET;
        end
        else if (conv_done)
        begin
            rb_res <= result_data;
            rb_cfg <= configuration_word;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            input_mode_field <= ACWSL_BIP_PAIRS;
        end
        else if (next_cfg[MODE_HI:MODE_LO+1] == MODE_BIP_PAIRS)
        begin
            input_mode_field <= ACWSL_BIP_PAIRS;
        end
        else if (next_cfg[MODE_HI:MODE_LO+1] == MODE_UNI_PAIRS)
        begin
            input_mode_field <= ACWSL_UNI_PAIRS;
        end
        else
        begin
            case (next_cfg[MODE_HI:MODE_LO])
                MODE_BIP_COM: input_mode_field <= ACWSL_BIP_COM;
                MODE_TEMP:    input_mode_field <= ACWSL_TEMP_SENSOR;
                MODE_UNI_GS:  input_mode_field <= ACWSL_UNI_GND_SENSE;
                MODE_UNI_SE:  input_mode_field <= ACWSL_UNI_SINGLE;
                default:      input_mode_field <= ACWSL_BIP_PAIRS;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_select_field <= 3'h0;
        end
        else
        begin
            channel_select_field <= next_cfg[CHAN_HI:CHAN_LO];
        end
    end

    // Codes marked do-not-use fall through to the internal reference.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_ext    <= 1'b0;
            ref_int_en <= 1'b1;
            ref_buf_en <= 1'b1;
            temp_en    <= 1'b1;
        end
        else
        begin
            case (next_cfg[REF_HI:REF_LO])
                REF_EXT_NOBUF:
                begin
                    ref_ext    <= 1'b1;
                    ref_int_en <= 1'b1;
                    ref_buf_en <= 1'b0;
                    temp_en    <= 1'b1;
                end
                REF_EXT_BUF:
                begin
                    ref_ext    <= 1'b1;
                    ref_int_en <= 1'b1;
                    ref_buf_en <= 1'b1;
                    temp_en    <= 1'b1;
                end
                REF_ALL_OFF:
                begin
                    ref_ext    <= 1'b1;
                    ref_int_en <= 1'b0;
                    ref_buf_en <= 1'b0;
                    temp_en    <= 1'b0;
                end
                default:
                begin
                    ref_ext    <= 1'b0;
                    ref_int_en <= 1'b1;
                    ref_buf_en <= 1'b1;
                    temp_en    <= 1'b1;
                end
            endcase
        end
    end

    a_bit_count_cap: assert property (@(posedge sck) disable iff (!frame_rst_n)
        bit_cnt <= CNT_CFG)
        else $error("serial bit counter passed fourteen");

    a_shift_msb_first: assert property (@(posedge sck) disable iff (!frame_rst_n)
        bit_cnt < CNT_CFG |=> shift_word[0] == $past(din))
        else $error("data-in bit not shifted into word LSB");

    a_keep_on_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_evt && !shift_word[UPD_BIT] && !conv_done |=> pend_valid == $past(pend_valid)
        && pend_word == $past(pend_word))
        else $error("word with update bit clear changed pending state");

    a_write_on_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_evt && shift_word[UPD_BIT] |=> pend_valid && pend_word == $past(shift_word))
        else $error("word with update bit set not taken");

    // An update landing on the conversion-end cycle stays pending for the next end
    a_apply_at_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_done && pend_valid |=> configuration_word == $past(pend_word)
        && (!pend_valid || $past(word_evt)))
        else $error("pending word not applied at conversion end");

    a_hold_mid_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !conv_done |=> $stable(configuration_word))
        else $error("configuration changed outside conversion end");

    a_readback_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_done |=> rb_cfg == $past(configuration_word) && rb_res == $past(result_data))
        else $error("readback word not tagged with active configuration");

    a_mode_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        configuration_word[MODE_HI:MODE_LO] == MODE_TEMP |-> input_mode_field == ACWSL_TEMP_SENSOR)
        else $error("temperature mode not decoded");

    a_mode_unipolar: assert property (@(posedge ref_clk) disable iff (!rst_n)
        configuration_word[MODE_HI:MODE_LO] == MODE_UNI_SE |-> input_mode_field == ACWSL_UNI_SINGLE)
        else $error("single-ended unipolar mode not decoded");

    a_chan_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
        channel_select_field == configuration_word[CHAN_HI:CHAN_LO])
        else $error("channel index differs from active word");

    a_ref_all_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        configuration_word[REF_HI:REF_LO] == REF_ALL_OFF |-> ref_ext && !ref_int_en && !ref_buf_en
        && !temp_en)
        else $error("reference all-off code not decoded");
endmodule
`default_nettype wire

// ---- tb/acwsl_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module acwsl_host_model
(
    output var  logic sck,
    output var  logic cnv,
    output var  logic din,
    input  wire logic sdo
);
    initial
    begin
        sck = 1'b0;
        cnv = 1'b1;
        din = 1'b1;
    end

    // Serial clock stands low outside frames; offset keeps it off the ref_clk grid
    task automatic frame(input logic [13:0] w, output logic [29:0] got);
        #1 cnv = 1'b0;
        #75;
        for (int i = 0; i < 30; i++)
        begin
            din = (i < 14) ? w[13 - i] : 1'b0;
            #40 sck = 1'b1;
            #80 sck = 1'b0;
            #40 got[29 - i] = sdo;
        end
        cnv = 1'b1;
        din = ~din;
    endtask
endmodule
`default_nettype wire

// ---- tb/adc_config_word_serial_load_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_config_word_serial_load_tb_top;
    import acwsl_pkg::*;

    logic              ref_clk;
    logic              rst_n;
    logic              readback_en;
    logic              conv_done;
    logic [RES_W-1:0]  result_data;
    wire logic         sck;
    wire logic         cnv;
    wire logic         din;
    logic              sdo;
    logic [CFG_W-1:0]  configuration_word;
    acwsl_mode_e       input_mode_field;
    logic [2:0]        channel_select_field;
    logic              ref_ext;
    logic              ref_int_en;
    logic              ref_buf_en;
    logic              temp_en;
    int                bad_count;
    int                checks_done;
    logic [29:0]       got;
    logic [13:0]       cur;

    acwsl_core dut_u
    (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .sck                  (sck),
        .cnv                  (cnv),
        .din                  (din),
        .readback_en          (readback_en),
        .conv_done            (conv_done),
        .result_data          (result_data),
        .sdo                  (sdo),
        .configuration_word   (configuration_word),
        .input_mode_field     (input_mode_field),
        .channel_select_field (channel_select_field),
        .ref_ext              (ref_ext),
        .ref_int_en           (ref_int_en),
        .ref_buf_en           (ref_buf_en),
        .temp_en              (temp_en)
    );

    acwsl_host_model host_u
    (
        .sck (sck),
        .cnv (cnv),
        .din (din),
        .sdo (sdo)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [29:0] exp, input logic [29:0] act);
        checks_done++;
        if (act !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t exp %h got %h", $time, exp, act);
        end
    endtask

    task automatic cdone(input logic [15:0] r);
        @(posedge ref_clk) #1 conv_done = 1'b1;
        result_data = r;
        @(posedge ref_clk) #1 conv_done = 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [13:0] w);
        host_u.frame(w, got);
        repeat (8) @(posedge ref_clk);
    endtask

    function automatic acwsl_mode_e exp_mode(input logic [2:0] c);
        case (c)
            3'h2:    return ACWSL_BIP_COM;
            3'h3:    return ACWSL_TEMP_SENSOR;
            3'h4:    return ACWSL_UNI_PAIRS;
            3'h5:    return ACWSL_UNI_PAIRS;
            3'h6:    return ACWSL_UNI_GND_SENSE;
            3'h7:    return ACWSL_UNI_SINGLE;
            default: return ACWSL_BIP_PAIRS;
        endcase
    endfunction

    task automatic t_reset();
        chk(30'h0, {16'h0, configuration_word});
        chk({27'h0, ACWSL_BIP_PAIRS}, {27'h0, input_mode_field});
        chk(30'h7, {26'h0, ref_ext, ref_int_en, ref_buf_en, temp_en});
    endtask

    // Word must wait in pending until the conversion ends
    task automatic t_apply();
        wr(14'h3d9b);
        chk({16'h0, cur}, {16'h0, configuration_word});
        cdone(16'h0);
        cur = 14'h3d9b;
        chk({16'h0, cur}, {16'h0, configuration_word});
        chk(30'h3, {27'h0, channel_select_field});
    endtask

    task automatic t_keep();
        wr(14'h3000);
        wr(14'h1fff);
        cdone(16'h0);
        cur = 14'h3000;
        chk({16'h0, cur}, {16'h0, configuration_word});
        wr(14'h1555);
        cdone(16'h0);
        chk({16'h0, cur}, {16'h0, configuration_word});
    endtask

    task automatic t_decode();
        logic [2:0] rc [4] = '{3'h1, 3'h2, 3'h3, 3'h6};
        logic [3:0] re [4] = '{4'h7, 4'hd, 4'hf, 4'h8};
        for (int i = 0; i < 8; i++)
        begin
            cur = {1'b1, i[2:0], i[2:0], 1'b0, rc[i % 4], 3'h0};
            wr(cur);
            cdone(16'h0);
            chk({16'h0, cur}, {16'h0, configuration_word});
            chk({27'h0, exp_mode(i[2:0])}, {27'h0, input_mode_field});
            chk({27'h0, i[2:0]}, {27'h0, channel_select_field});
            chk({26'h0, re[i % 4]}, {26'h0, ref_ext, ref_int_en, ref_buf_en, temp_en});
        end
    endtask

    task automatic t_readback();
        @(posedge ref_clk) #1 readback_en = 1'b1;
        cdone(16'ha5c3);
        host_u.frame(14'h0, got);
        chk({16'ha5c3, cur}, got);
        @(posedge ref_clk) #1 readback_en = 1'b0;
        cdone(16'h3c5a);
        host_u.frame(14'h0, got);
        chk({16'h3c5a, 14'h0}, got);
    endtask

    initial
    begin
        #200us;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        readback_en = 1'b0;
        conv_done = 1'b0;
        result_data = 16'h0;
        bad_count = 0;
        checks_done = 0;
        cur = 14'h0;
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        @(posedge ref_clk) #1;
        t_reset();
        // Power-up contents are not trusted until two conversions have passed
        cdone(16'h0);
        cdone(16'h0);
        t_apply();
        t_keep();
        t_decode();
        t_readback();
        tally_and_finish();
    end
endmodule
`default_nettype wire
